// ===== hdl/two_level_event_controller.sv
`timescale 1ns/1ps
`include "event_ctl_regs.svh"

module two_level_event_controller #(
  parameter int NUM_PERIPH = `NUM_PERIPH
) (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_srst,
  input  wire logic [`NUM_PERIPH-1:0] i_periph_irq,
  input  wire logic                 i_supervisor,
  input  wire logic                 i_gie_set,
  input  wire logic                 i_gie_clr,
  input  wire logic                 i_evt_accept,
  input  wire logic                 i_evt_return,
  input  wire logic                 i_core_idle,
  input  wire logic [`ADDR_W-1:0]   i_addr,
  input  wire logic [`DATA_W-1:0]   i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [`DATA_W-1:0]   o_rdata,
  output logic                      o_evt_req,
  output logic      [3:0]           o_evt_num,
  output logic      [`CORE_W-1:0]   o_core_pending,
  output logic                      o_wake_req
);

  event_ctl_pkg::core_state_t st_q;
  event_ctl_pkg::core_state_t st_d;

  logic [`NUM_PERIPH-1:0]            lines;
  logic [`NUM_PERIPH-1:0]            masked;
  logic [`NUM_PERIPH-1:0][`GEN_W-1:0] route_hot;
  logic [`GEN_W-1:0]                 route_or;
  logic [`GEN_W-1:0]                 gen_edge;
  logic [`CORE_W-1:0]                edge_vec;
  logic [`CORE_W-1:0]                cand;
  logic [`CORE_W-1:0]                acc_vec;
  logic [`CORE_W-1:0]                ret_vec;
  logic [4:0]                        cand_low;
  logic [4:0]                        pend_low;
  logic                              acc_fire;

  // Returns the index of the lowest set bit, or 16 when none is set.
  function automatic logic [4:0] lowest_set(input logic [`CORE_W-1:0] v);
    logic [4:0] r;
    r = 5'h10;
    for (int i = `CORE_W - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : lowest_set

  ////////////////////////////////////////////////////////////////////////////
  // System stage: synchronise, mask and route peripheral lines.

  // Peripheral lines come from other logic domains, so two flops first.
  line_sync #(
    .WIDTH (`NUM_PERIPH)
  ) u_line_sync (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_lines   (i_periph_irq),
    .o_lines   (lines)
  );

  assign masked = lines & st_q.pmask;

  // Each peripheral id picks its general input by a 4-bit field.
  for (genvar p = 0; p < `NUM_PERIPH; p++) begin : g_route
    assign route_hot[p] = masked[p] ?
      (`GEN_W'(1) << st_q.asgn[p / 8][(p % 8) * 4 +: 4]) : '0;
  end

  // Shared inputs are a plain OR, so overlapping pulses merge.
  always_comb begin
    route_or = '0;
    for (int p = 0; p < `NUM_PERIPH; p++) begin
      route_or = route_or | route_hot[p];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core stage: edge detection, dispatch and nesting.

  // Edge seen once the routed level is one cycle old.
  assign gen_edge = st_q.gen & ~st_q.gen_prev;
  assign edge_vec = {gen_edge, `GEN_BASE'(0)};

  // Unmasked latched events; general ones also need the global enable.
  assign cand = st_q.latch & st_q.mask &
    {{`GEN_W{st_q.gie}}, {`GEN_BASE{1'b1}}};

  assign cand_low = lowest_set(cand);
  assign pend_low = lowest_set(st_q.pend);
  assign acc_fire = i_evt_accept & st_q.req;
  assign acc_vec  = acc_fire ? (`CORE_W'(1) << st_q.num) : '0;
  assign ret_vec  = (i_evt_return && pend_low != 5'h10) ?
    (`CORE_W'(1) << pend_low[3:0]) : '0;

  // Next-state logic for the whole controller.
  always_comb begin
    st_d          = st_q;
    st_d.gen      = route_or;
    st_d.gen_prev = st_q.gen;
    // Disable wins if both instructions retire together.
    if (i_gie_clr) begin
      st_d.gie = 1'b0;
    end else if (i_gie_set) begin
      st_d.gie = 1'b1;
    end
    // Register writes.
    if (i_wr) begin
      case (i_addr)
        `ADR_LATCH: begin
          st_d.latch = (st_q.latch & st_q.mask) |
            (i_wdata[`CORE_W-1:0] & ~st_q.mask);
        end
        `ADR_MASK: begin
          if (i_supervisor) begin
            st_d.mask = i_wdata[`CORE_W-1:0];
          end
        end
        `ADR_PMASK0: st_d.pmask[31:0] = i_wdata;
        `ADR_PMASK1: st_d.pmask[`NUM_PERIPH-1:32] = i_wdata[`PHI_W-1:0];
        `ADR_WAKE0:  st_d.wake[31:0] = i_wdata;
        `ADR_WAKE1:  st_d.wake[`NUM_PERIPH-1:32] = i_wdata[`PHI_W-1:0];
        default: begin
          if (i_addr >= `ADR_ASGN0 && i_addr <= `ADR_ASGN6) begin
            st_d.asgn[3'(i_addr - `ADR_ASGN0)] = i_wdata;
          end
        end
      endcase
    end
    // Acceptance clears the latch; a new edge in that cycle still wins.
    st_d.latch = (st_d.latch & ~acc_vec) | edge_vec;
    // Return retires the innermost level, accept opens a new one.
    st_d.pend = (st_q.pend & ~ret_vec) | acc_vec;
    // Forwarded flag holds until pending acknowledges it.
    st_d.fwd = (st_q.fwd & ~acc_vec[`CORE_W-1:`GEN_BASE]) | gen_edge;
    // Dispatch only an event of higher priority than all active ones.
    st_d.req = 1'b0;
    st_d.num = st_q.num;
    if (!acc_fire && cand_low < pend_low) begin
      st_d.req = 1'b1;
      st_d.num = cand_low[3:0];
    end
    st_d.wake_req = i_core_idle && |(lines & st_q.wake);
    // Read data stands only in the cycle after the read strobe.
    st_d.rdata = '0;
    if (i_rd) begin
      case (i_addr)
        `ADR_LATCH: st_d.rdata = {16'h0000, st_q.latch};
        `ADR_MASK: begin
          if (i_supervisor) begin
            st_d.rdata = {16'h0000, st_q.mask};
          end
        end
        `ADR_PEND: begin
          if (i_supervisor) begin
            st_d.rdata = {16'h0000, st_q.pend};
          end
        end
        `ADR_CTL: begin
          st_d.rdata[`CTL_GIE_BIT] = st_q.gie;
          st_d.rdata[`CTL_FWD_LSB +: `GEN_W] = st_q.fwd;
        end
        `ADR_PMASK0: st_d.rdata = st_q.pmask[31:0];
        `ADR_PMASK1: st_d.rdata = {8'h00, st_q.pmask[`NUM_PERIPH-1:32]};
        `ADR_PSTAT0: st_d.rdata = lines[31:0];
        `ADR_PSTAT1: st_d.rdata = {8'h00, lines[`NUM_PERIPH-1:32]};
        `ADR_WAKE0:  st_d.rdata = st_q.wake[31:0];
        `ADR_WAKE1:  st_d.rdata = {8'h00, st_q.wake[`NUM_PERIPH-1:32]};
        default: begin
          if (i_addr >= `ADR_ASGN0 && i_addr <= `ADR_ASGN6) begin
            st_d.rdata = st_q.asgn[3'(i_addr - `ADR_ASGN0)];
          end
        end
      endcase
    end
  end

  // State register with routing defaults loaded at reset.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      st_q      <= '0;
      st_q.asgn <= {`ASGN_RST6, `ASGN_RST5, `ASGN_RST4, `ASGN_RST3,
                    `ASGN_RST2, `ASGN_RST1, `ASGN_RST0};
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register.
  assign o_rdata        = st_q.rdata;
  assign o_evt_req      = st_q.req;
  assign o_evt_num      = st_q.num;
  assign o_core_pending = st_q.pend;
  assign o_wake_req     = st_q.wake_req;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the controller's own behaviour.

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_srst);

  logic [3:0] num_past;
  logic       edge_past;

  // Helper copies; the checks below compare against num_past only.
  always_ff @(posedge i_sys_clk) begin
    num_past  <= st_q.num;
    edge_past <= edge_vec[st_q.num];
  end

  edge_sets_latch_a: assert property (
    gen_edge[5] |=> st_q.latch[`GEN_BASE + 5])
    else $error("edge did not set its latch bit");

  accept_clears_a: assert property (
    acc_fire && !edge_vec[st_q.num] |=> !st_q.latch[num_past])
    else $error("accepted event still latched");

  accept_pends_a: assert property (
    acc_fire |=> st_q.pend[num_past] && !st_q.req)
    else $error("accepted event not pending");

  req_unmasked_a: assert property (
    o_evt_req |-> st_q.mask[o_evt_num] && st_q.latch[o_evt_num])
    else $error("dispatched a masked or unlatched event");

  req_gie_a: assert property (
    o_evt_req && o_evt_num >= 4'h7 |-> st_q.gie)
    else $error("general event dispatched while disabled");

  req_nests_a: assert property (
    o_evt_req |-> 5'(o_evt_num) < lowest_set(st_q.pend))
    else $error("dispatch does not outrank active events");

  mask_priv_a: assert property (
    i_rd && !i_supervisor && i_addr == `ADR_MASK |=> o_rdata == '0)
    else $error("mask readable outside supervisor mode");

  status_read_a: assert property (
    i_rd && i_addr == `ADR_PSTAT0 |=> o_rdata == $past(lines[31:0]))
    else $error("status read does not match lines");

  wake_idle_a: assert property (
    !i_core_idle |=> !o_wake_req)
    else $error("wake raised while core busy");

  latency_min_a: assert property (
    $rose(route_or[5]) && !st_q.gen[5] |->
      ##1 !$rose(st_q.pend[`GEN_BASE + 5]) [*2])
    else $error("pending rose faster than three cycles");

  latch_write_a: assert property (
    i_wr && i_addr == `ADR_LATCH && st_q.mask[3] && !acc_vec[3]
      |=> st_q.latch[3] == $past(st_q.latch[3]))
    else $error("latch written while its mask bit set");

  cov_nest_c: cover property (
    st_q.pend[`GEN_BASE + 4] ##[1:20] acc_fire && st_q.num == 4'h7);
  cov_wake_c: cover property (o_wake_req);
  cov_shared_c: cover property (st_q.req && edge_vec[st_q.num]);

endmodule : two_level_event_controller

// ===== hdl/event_ctl_regs.svh
// Functional notes
// - Core stage: latch, mask, pending, 16 bits
// - Latch bit set on event, cleared on acceptance
// - Software writes latch bit only when masked
// - Set core mask bit lets event service
// - Core mask access only in supervisor mode
// - Global enable/disable instructions gate general events
// - Pending tracks nested active events, supervisor read
// - Three pairs of 32-bit peripheral registers
// - Peripheral mask bit passes or blocks event
// - Status bit shows peripheral line asserting
// - Wake-enabled event raises wake when idle
// - Shared inputs tolerate simultaneous pulse assertions
// - Pending bits acknowledge forwarded peripheral events
// - Rising edge sets latch, two-cycle detection
// - Latch bit cleared as pending bit sets
// - Further edge queued once pending is set
// - Edge to pending output at least three cycles
// - Assignment registers route ids 0-55 to inputs
`ifndef EVENT_CTL_REGS_SVH
`define EVENT_CTL_REGS_SVH

`define CORE_W       16
`define GEN_W        9
`define GEN_BASE     7
`define NUM_PERIPH   56
`define PHI_W        24
`define NUM_ASGN     7
`define ADDR_W       5
`define DATA_W       32
`define SYNC_STAGES  2

`define ADR_LATCH    5'h00
`define ADR_MASK     5'h01
`define ADR_PEND     5'h02
`define ADR_CTL      5'h03
`define ADR_PMASK0   5'h04
`define ADR_PMASK1   5'h05
`define ADR_PSTAT0   5'h06
`define ADR_PSTAT1   5'h07
`define ADR_WAKE0    5'h08
`define ADR_WAKE1    5'h09
`define ADR_ASGN0    5'h0A
`define ADR_ASGN6    5'h10

`define CTL_GIE_BIT  0
`define CTL_FWD_LSB  8

`define ASGN_RST0    32'h00000000
`define ASGN_RST1    32'h11000000
`define ASGN_RST2    32'h33332222
`define ASGN_RST3    32'h44444433
`define ASGN_RST4    32'h55555555
`define ASGN_RST5    32'h06666655
`define ASGN_RST6    32'h33333000

`endif

// ===== hdl/event_ctl_pkg.sv
`include "event_ctl_regs.svh"

package event_ctl_pkg;

  typedef logic [`NUM_ASGN-1:0][`DATA_W-1:0] asgn_arr_t;

  // Complete state of the two-level event controller.
  typedef struct packed {
    logic [`CORE_W-1:0]     latch;
    logic [`CORE_W-1:0]     mask;
    logic [`CORE_W-1:0]     pend;
    logic                   gie;
    logic [`NUM_PERIPH-1:0] pmask;
    logic [`NUM_PERIPH-1:0] wake;
    asgn_arr_t              asgn;
    logic [`GEN_W-1:0]      gen;
    logic [`GEN_W-1:0]      gen_prev;
    logic [`GEN_W-1:0]      fwd;
    logic                   req;
    logic [3:0]             num;
    logic                   wake_req;
    logic [`DATA_W-1:0]     rdata;
  } core_state_t;

endpackage : event_ctl_pkg

// ===== hdl/line_sync.sv
`timescale 1ns/1ps

module line_sync #(
  parameter int WIDTH = 56
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_srst,
  input  wire logic [WIDTH-1:0] i_lines,
  output logic      [WIDTH-1:0] o_lines
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_t;

  sync_t st_q;
  sync_t st_d;

  // Two flops; only the second stage is read outside this module.
  always_comb begin
    st_d    = st_q;
    st_d.s1 = i_lines;
    st_d.s2 = st_q.s1;
  end

  // State register.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_lines = st_q.s2;

endmodule : line_sync

// ===== verif/event_pipe_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Pipeline side: takes a requested event after a chosen stall of cycles.
module event_pipe_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_srst,
  input  wire logic       i_evt_req,
  input  wire logic [3:0] i_stall,
  output logic            o_evt_accept
);
  logic [3:0] wait_q;

  // Accepts only while a request stands, one pulse per request.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst || !i_evt_req || o_evt_accept) begin
      wait_q       <= 4'h0;
      o_evt_accept <= 1'b0;
    end else if (wait_q >= i_stall) begin
      o_evt_accept <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : event_pipe_model

// ===== verif/two_level_event_controller_test.sv
`timescale 1ns/1ps
`include "event_ctl_regs.svh"

module two_level_event_controller_test;
  logic        clk = 1'b0;
  logic        srst, sup, gset, gclr, acc, ret, idle, wr, rd, req, wake;
  logic [55:0] irq;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  num, stall;
  logic [15:0] pend;
  int          err_count, cmp_count, n;

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  two_level_event_controller uut (.i_sys_clk(clk), .i_srst(srst),
    .i_periph_irq(irq), .i_supervisor(sup), .i_gie_set(gset),
    .i_gie_clr(gclr), .i_evt_accept(acc), .i_evt_return(ret),
    .i_core_idle(idle), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_evt_req(req), .o_evt_num(num),
    .o_core_pending(pend), .o_wake_req(wake));

  event_pipe_model pipe (.i_sys_clk(clk), .i_srst(srst), .i_evt_req(req),
    .i_stall(stall), .o_evt_accept(acc));

  ////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Compares a seen value with the expected one.
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One-cycle register write.
  task automatic wr_reg(logic [4:0] a, logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // One-cycle register read; data stands in the following cycle.
  task automatic rd_reg(logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // Reads a register and compares it.
  task automatic rd_chk(string nm, logic [4:0] a, logic [31:0] exp);
    rd_reg(a, v);
    check(nm, v, exp);
  endtask : rd_chk

  // Drives a one-cycle pulse: 0 return, 1 enable, 2 disable.
  task automatic pulse(int s);
    @(posedge clk);
    case (s)
      0: ret <= 1'b1;
      1: gset <= 1'b1;
      default: gclr <= 1'b1;
    endcase
    @(posedge clk);
    {ret, gset, gclr} <= 3'b000;
  endtask : pulse

  task automatic tick(int c);
    repeat (c) @(posedge clk);
  endtask : tick

  // Waits a bounded time for a request and checks its event number.
  task automatic wait_req(logic [3:0] exp);
    for (n = 0; n < 40 && req !== 1'b1; n++) @(posedge clk);
    if (req !== 1'b1) begin
      err_count++;
      give_verdict();
    end
    #1 check("evt_num", 32'(num), 32'(exp));
  endtask : wait_req

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    {srst, sup, gset, gclr, ret, idle, wr, rd} = 8'hFF ^ 8'h7F;
    {irq, addr, wdata, stall} = '0;
    err_count = 0;
    cmp_count = 0;
    tick(2);
    srst <= 1'b0;
    sup  <= 1'b1;
    rd_chk("mask", `ADR_MASK, 32'h00000000);
    rd_chk("pend", `ADR_PEND, 32'h00000000);
    rd_chk("unmapped", 5'h1F, 32'h00000000);
    sup <= 1'b0;
    wr_reg(`ADR_MASK, 32'h0000FFFF);
    rd_chk("mask", `ADR_MASK, 32'h00000000);
    sup <= 1'b1;
    rd_chk("mask", `ADR_MASK, 32'h00000000);
    wr_reg(`ADR_LATCH, 32'h00000028);
    rd_chk("latch", `ADR_LATCH, 32'h00000028);
    check("req", 32'(req), 32'h0);
    wr_reg(`ADR_MASK, 32'h00000028);
    wait_req(4'h3);
    tick(3);
    check("req", 32'(req), 32'h0);
    check("pend", 32'(pend), 32'h00000008);
    rd_chk("latch", `ADR_LATCH, 32'h00000020);
    pulse(0);
    wait_req(4'h5);
    tick(3);
    pulse(0);
    wr_reg(`ADR_LATCH, 32'h00000008);
    rd_chk("latch", `ADR_LATCH, 32'h00000000);
    wr_reg(`ADR_MASK, 32'h00001000);
    irq[33] <= 1'b1;
    tick(4);
    rd_chk("status1", `ADR_PSTAT1, 32'h00000002);
    rd_chk("latch", `ADR_LATCH, 32'h00000000);
    idle <= 1'b1;
    wr_reg(`ADR_WAKE1, 32'h00000002);
    tick(3);
    check("wake", 32'(wake), 32'h1);
    idle <= 1'b0;
    tick(3);
    check("wake", 32'(wake), 32'h0);
    wr_reg(`ADR_PMASK1, 32'h00000002);
    tick(8);
    check("req", 32'(req), 32'h0);
    rd_chk("latch", `ADR_LATCH, 32'h00001000);
    rd_chk("ctl", `ADR_CTL, 32'h00002000);
    pulse(1);
    wait_req(4'hC);
    tick(3);
    check("pend", 32'(pend), 32'h00001000);
    rd_chk("latch", `ADR_LATCH, 32'h00000000);
    irq[33] <= 1'b0;
    tick(3);
    irq[33] <= 1'b1;
    tick(6);
    rd_chk("latch", `ADR_LATCH, 32'h00001000);
    pulse(0);
    wait_req(4'hC);
    tick(3);
    pulse(0);
    irq[33] <= 1'b0;
    stall   <= 4'h3;
    tick(4);
    irq[33] <= 1'b1;
    @(posedge clk);
    for (n = 0; n < 30 && pend[12] !== 1'b1; n++) @(posedge clk);
    check("latency", 32'(n >= 2), 32'h1);
    pulse(0);
    tick(2);
    rd_chk("ctl", `ADR_CTL, 32'h00000001);
    pulse(2);
    rd_chk("ctl", `ADR_CTL, 32'h00000000);
    give_verdict();
  end
endmodule : two_level_event_controller_test
